//--- verilog/i2cbt_pkg.sv
// Constants, register map and state codes for the I2C bit interface
package i2cbt_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_CTRL  = 4'h0; // Control / flags
  localparam logic [3:0] ADDR_DATA  = 4'h1; // Serial data
  localparam logic [3:0] ADDR_CFG   = 4'h2; // Configuration
  localparam logic [3:0] ADDR_IRQ_ENABLE_REG_SECOND  = 4'h3; // Second irq enable
  localparam logic [3:0] ADDR_IRQ_ENABLE_REG_FIRST  = 4'h4; // First irq enable
  localparam logic [3:0] ADDR_IP1   = 4'h5; // Second prio low
  localparam logic [3:0] ADDR_PRIO_REG_SECOND_HIGH  = 4'h6; // Second prio high
  localparam logic [3:0] ADDR_ISTAT = 4'h7; // Event status
  localparam logic [3:0] ADDR_IMASK = 4'h8; // Event mask

  // ==========================================================
  // Field positions
  localparam int BIT_TMR_IE  = 7; // Bus timer enable / prio
  localparam int BIT_SER_IE  = 0; // Serial enable / prio
  localparam int BIT_GLB_IE  = 7; // Global enable
  localparam int BIT_CFG_SLV = 7; // Slave enable
  localparam int BIT_CFG_MRQ = 6; // Master request
  localparam int BIT_CFG_RUN = 4; // Bus timer run
  localparam int BIT_CFG_PSH = 1; // Prescale select hi
  localparam int BIT_CFG_PSL = 0; // Prescale select lo
  localparam int EV_DATA_READY_FLAG = 0;     // Event bit positions
  localparam int EV_ARL  = 1;
  localparam int EV_STR  = 2;
  localparam int EV_STP  = 3;
  localparam int EV_TMO  = 4;

  // ==========================================================
  // Reset values
  localparam logic       SYNC_RST  = 1'b1;  // Idle bus level
  localparam logic [4:0] IMASK_RST = 5'h1f; // All events unmasked

  // ==========================================================
  // Timer preloads per prescale select
  localparam logic [2:0] PRELOAD_0 = 3'h0;
  localparam logic [2:0] PRELOAD_1 = 3'h2;
  localparam logic [2:0] PRELOAD_2 = 3'h4;
  localparam logic [2:0] PRELOAD_3 = 3'h6;
  localparam logic [2:0] SPAN_LAST = 3'h7;  // Low timer bits full
  localparam logic [9:0] TMO_LAST  = 10'h3ff; // Full timer

  // ==========================================================
  // Timing
  localparam int MIN_SPAN_NS   = 4700000; // 4.7 ms
  localparam int CLK_PERIOD_NS = 5;
  localparam int MIN_SPAN_CYC  = (MIN_SPAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CLKS     = MIN_SPAN_CYC / 8; // One timer count

  // ==========================================================
  // Master sequencer states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_LOW   = 6'h04,
    ST_HIGH  = 6'h08,
    ST_STOP  = 6'h10,
    ST_RSTRT = 6'h20
  } i2cbt_state_e;

endpackage

//--- verilog/i2cbt_top.sv
// I2C bit-level interface with bus timer and register port
`timescale 1ns/1ps
module i2cbt_top #(
  parameter int P_TICK_CLKS = i2cbt_pkg::TICK_CLKS
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // I2C pins
  input  wire logic       i_scl,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  // Interrupt and priorities
  output logic            o_irq,
  output logic      [1:0] o_tmr_prio,
  output logic      [1:0] o_ser_prio
);
  import i2cbt_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic         scl_m;     // Sync stage one
    logic         scl_s;     // Sync stage two
    logic         scl_p;     // Previous synced SCL
    logic         sda_m;
    logic         sda_s;
    logic         sda_p;
    i2cbt_state_e st;        // Master sequencer
    logic         scl_oe;    // SCL pulled low
    logic         sda_oe;    // SDA pulled low
    logic [16:0]  tick_cnt;  // Timer count divider
    logic [2:0]   span;      // Low timer bits
    logic         span_done; // Minimum span reached
    logic [9:0]   tmo;       // Full timeout timer
    logic         frame;     // Frame in progress
    logic         master;    // Acting as master
    logic         xa;        // Transmit active
    logic         txbit;     // Bit to send
    logic         idle;      // Slave ignores bus
    logic         rdat;      // Last received bit
    logic         data_ready_flag;      // Data ready flag
    logic         arbitration_lost_flag;       // Arbitration lost flag
    logic         str;       // Start seen flag
    logic         stop_seen_flag;       // Stop seen flag
    logic         xstr_pend; // Repeated start requested
    logic         xstp_pend; // Stop requested
    logic         slave_en;  // Slave enable
    logic         mreq;      // Master request
    logic         run;       // Bus timer run
    logic [1:0]   ps;        // Prescale select
    logic         ien_t;     // Bus timer irq enable
    logic         ien_s;     // Serial irq enable
    logic         ien_g;     // Global irq enable
    logic         ipl_t;     // Priority bits
    logic         ipl_s;
    logic         iph_t;
    logic         iph_s;
    logic [4:0]   istat;     // Sticky events
    logic [4:0]   imask;     // Event mask
    logic [7:0]   rdata;     // Read data
  } i2cbt_regs_s;

  i2cbt_regs_s q;            // Registered state
  i2cbt_regs_s n;            // Next state

  logic       scl_rise;      // Synced SCL edges
  logic       scl_fall;
  logic       start_det;     // Bus conditions
  logic       stop_det;
  logic       active;        // Master or awake slave
  logic       tick;          // One timer count
  logic       restart;       // Reload span timer
  logic       tmo_carry;     // Timeout overflow
  logic [2:0] preload;       // Selected preload
  logic [4:0] ien_vec;       // Per-event enables

  // ==========================================================
  // Next-state logic
  always_comb begin
    n = q;
    restart = 1'b0;
    // Two-stage synchronisers
    n.scl_m = i_scl;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = i_sda;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    // Edge and condition detection
    scl_rise  = q.scl_s & ~q.scl_p;
    scl_fall  = ~q.scl_s & q.scl_p;
    start_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop_det  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    active    = q.master | (q.slave_en & ~q.idle);

    tick = (q.tick_cnt == 17'(P_TICK_CLKS - 1));
    n.tick_cnt = tick ? 17'h0 : q.tick_cnt + 17'h1;
    case (q.ps)
      2'h0:    preload = PRELOAD_0;
      2'h1:    preload = PRELOAD_1;
      2'h2:    preload = PRELOAD_2;
      default: preload = PRELOAD_3;
    endcase
    if (tick & ~q.span_done) begin
      if (q.span == SPAN_LAST) begin
        n.span_done = 1'b1;
      end else begin
        n.span = q.span + 3'h1;
      end
    end

    // held idle outside frames, needs run bit
    if (~q.frame | ~q.run | scl_rise | scl_fall) begin
      n.tmo = 10'h0;
    end else if (tick) begin
      n.tmo = q.tmo + 10'h1;
    end
    tmo_carry = q.run & q.frame & tick & (q.tmo == TMO_LAST);

    // Master sequencer
    case (q.st)
      ST_IDLE: begin
        // slave stretches low while data ready
        n.scl_oe = active & q.data_ready_flag & ~q.scl_s;
        // Slave data bit changes only while SCL low
        if (~q.scl_s) begin
          n.sda_oe = active & q.xa & ~q.txbit;
        end
        // Start after bus-free gap
        if (q.mreq & ~q.frame & q.span_done & q.scl_s & q.sda_s) begin
          n.sda_oe = 1'b1;
          n.master = 1'b1;
          n.st     = ST_START;
          restart  = 1'b1;
        end
      end
      ST_START: begin
        // SDA low to SCL low span
        if (q.span_done) begin
          n.scl_oe = 1'b1;
          n.st     = ST_LOW;
          restart  = 1'b1;
        end
      end
      ST_LOW: begin
        n.scl_oe = 1'b1;
        if (~q.scl_s) begin
          n.sda_oe = q.xa & ~q.txbit;
        end
        // hold low until serviced and min low
        if (q.span_done & ~q.data_ready_flag) begin
          n.scl_oe = 1'b0;
          restart  = 1'b1;
          if (q.xstp_pend) begin
            // Stop is not data: no arbitration on its SCL rise
            n.xa        = 1'b0;
            n.sda_oe    = 1'b1;
            n.xstp_pend = 1'b0;
            n.st        = ST_STOP;
          end else if (q.xstr_pend) begin
            n.sda_oe    = 1'b0;
            n.xstr_pend = 1'b0;
            n.st        = ST_RSTRT;
          end else begin
            n.st = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        // min high counts once SCL is really high
        if (~q.scl_s) begin
          restart = 1'b1;
        end else if (q.span_done) begin
          n.scl_oe = 1'b1;
          n.st     = ST_LOW;
          restart  = 1'b1;
        end
      end
      ST_STOP: begin
        // SCL high to SDA high span
        if (~q.scl_s) begin
          restart = 1'b1;
        end else if (q.span_done) begin
          // Mastership ends once the stop is seen on the bus
          n.sda_oe = 1'b0;
          n.st     = ST_IDLE;
          restart  = 1'b1;
        end
      end
      ST_RSTRT: begin
        // Both released, then start again
        if (~q.scl_s) begin
          restart = 1'b1;
        end else if (q.span_done) begin
          n.sda_oe = 1'b1;
          n.st     = ST_START;
          restart  = 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL: begin
          if (i_wdata[7]) n.xa = 1'b0;
          if (i_wdata[6]) n.idle = 1'b1;
          if (i_wdata[5]) n.data_ready_flag = 1'b0;
          if (i_wdata[4]) n.arbitration_lost_flag = 1'b0;
          if (i_wdata[3]) n.str = 1'b0;
          if (i_wdata[2]) n.stop_seen_flag = 1'b0;
          if (i_wdata[1]) n.xstr_pend = 1'b1;
          if (i_wdata[0]) n.xstp_pend = 1'b1;
        end
        ADDR_DATA: begin
          n.txbit = i_wdata[7];
          n.xa    = 1'b1;
          n.data_ready_flag  = 1'b0;
        end
        ADDR_CFG: begin
          n.slave_en = i_wdata[BIT_CFG_SLV];
          n.mreq     = i_wdata[BIT_CFG_MRQ];
          n.run      = i_wdata[BIT_CFG_RUN];
          n.ps       = {i_wdata[BIT_CFG_PSH], i_wdata[BIT_CFG_PSL]};
        end
        ADDR_IRQ_ENABLE_REG_SECOND: begin
          n.ien_t = i_wdata[BIT_TMR_IE];
          n.ien_s = i_wdata[BIT_SER_IE];
        end
        ADDR_IRQ_ENABLE_REG_FIRST:  n.ien_g = i_wdata[BIT_GLB_IE];
        ADDR_IP1: begin
          n.ipl_t = i_wdata[BIT_TMR_IE];
          n.ipl_s = i_wdata[BIT_SER_IE];
        end
        ADDR_PRIO_REG_SECOND_HIGH: begin
          n.iph_t = i_wdata[BIT_TMR_IE];
          n.iph_s = i_wdata[BIT_SER_IE];
        end
        ADDR_IMASK: n.imask = i_wdata[4:0];
        default: ;
      endcase
    end

    // Register reads, data valid next cycle
    n.rdata = 8'h0;
    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL: n.rdata = {q.rdat, q.data_ready_flag | q.arbitration_lost_flag | q.str | q.stop_seen_flag,
                              q.data_ready_flag, q.arbitration_lost_flag, q.str, q.stop_seen_flag, q.master, 1'b0};
        ADDR_DATA: begin
          n.rdata = {q.rdat, 7'h0};
          n.data_ready_flag  = 1'b0;
        end
        ADDR_CFG:   n.rdata = {q.slave_en, q.mreq, 1'b0, q.run, 2'h0, q.ps};
        ADDR_IRQ_ENABLE_REG_SECOND:  n.rdata = {q.ien_t, 6'h0, q.ien_s};
        ADDR_IRQ_ENABLE_REG_FIRST:  n.rdata = {q.ien_g, 7'h0};
        ADDR_IP1:   n.rdata = {q.ipl_t, 6'h0, q.ipl_s};
        ADDR_PRIO_REG_SECOND_HIGH:  n.rdata = {q.iph_t, 6'h0, q.iph_s};
        ADDR_ISTAT: begin
          n.rdata = {3'h0, q.istat};
          n.istat = 5'h0;
        end
        ADDR_IMASK: n.rdata = {3'h0, q.imask};
        default:    n.rdata = 8'h0;
      endcase
    end

    // bus events; they override register writes
    if (scl_rise & active) begin
      n.data_ready_flag = 1'b1;
      n.rdat = q.sda_s;
      n.istat[EV_DATA_READY_FLAG] = 1'b1;
      if (q.xa & q.txbit & ~q.sda_s) begin
        n.arbitration_lost_flag = 1'b1;
        n.xa  = 1'b0;
        n.istat[EV_ARL] = 1'b1;
        if (q.master) begin
          n.master = 1'b0;
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          n.st     = ST_IDLE;
        end
      end
    end
    if (start_det) begin
      n.frame = 1'b1;
      n.idle  = 1'b0;
      if (q.master | q.slave_en) begin
        n.str = 1'b1;
        n.istat[EV_STR] = 1'b1;
      end
    end
    if (stop_det) begin
      n.frame = 1'b0;
      n.xa    = 1'b0;
      if (active) begin
        n.stop_seen_flag = 1'b1;
        n.istat[EV_STP] = 1'b1;
      end
      // Own stop completes, so the master sees its stop flag
      if (q.st == ST_IDLE) begin
        n.master = 1'b0;
      end
      if (~q.master) begin
        restart = 1'b1;
      end
    end
    // reload span timer on phase entry
    if (restart) begin
      n.span      = preload;
      n.span_done = 1'b0;
    end
    if (tmo_carry) begin
      n.st        = ST_IDLE;
      n.master    = 1'b0;
      n.scl_oe    = 1'b0;
      n.sda_oe    = 1'b0;
      n.frame     = 1'b0;
      n.xa        = 1'b0;
      n.data_ready_flag      = 1'b0;
      n.xstr_pend = 1'b0;
      n.xstp_pend = 1'b0;
      n.tmo       = 10'h0;
      n.istat[EV_TMO] = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q           <= '0;
      q.scl_m     <= SYNC_RST;
      q.scl_s     <= SYNC_RST;
      q.scl_p     <= SYNC_RST;
      q.sda_m     <= SYNC_RST;
      q.sda_s     <= SYNC_RST;
      q.sda_p     <= SYNC_RST;
      q.st        <= ST_IDLE;
      q.span_done <= 1'b1;
      q.imask     <= IMASK_RST;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  // gated by global and per-source enables
  assign ien_vec    = {5{q.ien_g}} & {q.ien_t, {4{q.ien_s}}};
  assign o_irq      = |(q.istat & q.imask & ien_vec);
  assign o_tmr_prio = {q.iph_t, q.ipl_t};
  assign o_ser_prio = {q.iph_s, q.ipl_s};
  assign o_rdata    = q.rdata;
  assign o_scl_o    = 1'b0;
  assign o_scl_oe   = q.scl_oe;
  assign o_sda_o    = 1'b0;
  assign o_sda_oe   = q.sda_oe;

endmodule // i2cbt_top

//--- tb/i2cbt_properties.sv
// Port-level checks of the I2C bit interface
`timescale 1ns/1ps
module i2cbt_properties #(
  parameter int P_TICK_CLKS = 2
) (
  // Clock, reset, register port
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Bus pins, irq, priorities
  input wire logic       i_scl,
  input wire logic       o_scl_o,
  input wire logic       o_scl_oe,
  input wire logic       i_sda,
  input wire logic       o_sda_o,
  input wire logic       o_sda_oe,
  input wire logic       o_irq,
  input wire logic [1:0] o_tmr_prio,
  input wire logic [1:0] o_ser_prio
);
  import i2cbt_pkg::*;
  localparam int TMO_MAX = 1025 * P_TICK_CLKS + 8; // Latest release after SCL quiet
  logic        run_q;  // Timer run bit as last written
  logic        scl_q;  // SCL one cycle ago
  logic [15:0] idle_q; // Cycles since SCL change or config write
  // ==========================================
  // Helper state
  always_ff @(posedge i_clk) begin
    scl_q <= i_scl;
    if (!i_rst_b) run_q <= 1'b0;
    else if (i_wr && i_addr == ADDR_CFG) run_q <= i_wdata[BIT_CFG_RUN];
    if (!i_rst_b || i_scl != scl_q || (i_wr && i_addr == ADDR_CFG)) idle_q <= '0;
    else if (idle_q != 16'hffff) idle_q <= idle_q + 16'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // Assertions
  property p_rdata_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero");
  property p_open_drain; o_scl_o == 1'b0 && o_sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  property p_reset_idle;
    disable iff (1'b0) !i_rst_b |=> !o_scl_oe && !o_sda_oe && !o_irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs active after reset");
  property p_tmr_prio;
    i_wr && i_addr == ADDR_IP1 |=> o_tmr_prio[0] == $past(i_wdata[BIT_TMR_IE]);
  endproperty
  a_tmr_prio: assert property (p_tmr_prio)
    else $error("timer priority wrong");
  property p_ser_prio;
    i_wr && i_addr == ADDR_PRIO_REG_SECOND_HIGH |=> o_ser_prio[1] == $past(i_wdata[BIT_SER_IE]);
  endproperty
  a_ser_prio: assert property (p_ser_prio)
    else $error("serial priority wrong");
  property p_atn_or; i_rd && i_addr == ADDR_CTRL |=> o_rdata[6] == |o_rdata[5:2]; endproperty
  a_atn_or: assert property (p_atn_or)
    else $error("attention not OR of flags");
  property p_cdr_clear;
    i_wr && i_addr == ADDR_CTRL && i_wdata[5] ##2 i_rd && i_addr == ADDR_CTRL && idle_q > 16'd6
    |=> !o_rdata[5];
  endproperty
  a_cdr_clear: assert property (p_cdr_clear)
    else $error("data ready not cleared");
  property p_irq_global;
    i_wr && i_addr == ADDR_IRQ_ENABLE_REG_FIRST && !i_wdata[BIT_GLB_IE] |=> !o_irq;
  endproperty
  a_irq_global: assert property (p_irq_global)
    else $error("irq without global enable");
  property p_tmo_release; run_q && idle_q > TMO_MAX |-> !o_scl_oe; endproperty
  a_tmo_release: assert property (p_tmo_release)
    else $error("SCL held past timeout");
  property p_span; $fell(o_scl_oe) |=> !o_scl_oe [*2]; endproperty
  a_span: assert property (p_span)
    else $error("SCL high span too short");
  // Main scenarios reached
  c_irq: cover property (o_irq);
  c_tmo: cover property (run_q && $fell(o_scl_oe));
  c_istat: cover property (i_rd && i_addr == ADDR_ISTAT);
endmodule // i2cbt_properties
bind i2cbt_top i2cbt_properties #(.P_TICK_CLKS(P_TICK_CLKS)) u_i2cbt_properties (
  .i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_scl, .o_scl_o,
  .o_scl_oe, .i_sda, .o_sda_o, .o_sda_oe, .o_irq, .o_tmr_prio, .o_ser_prio);

//--- tb/i2cbt_bus_model.sv
// Other party on the two-wire bus, open drain with pull-ups
`timescale 1ns/1ps
module i2cbt_bus_model (
  // Clock and device pull-downs
  input  wire logic i_clk,
  input  wire logic i_scl_oe,
  input  wire logic i_sda_oe,
  // Wire levels
  output logic      o_scl,
  output logic      o_sda
);
  logic scl_pull = 1'b0; // Our SCL pull-down
  logic sda_pull = 1'b0; // Our SDA pull-down
  int   dly      = 4;    // Cycles per phase, prompt or slow
  // Wired AND, released lines float to the pull-up
  assign o_scl = ~((i_scl_oe === 1'b1) | scl_pull);
  assign o_sda = ~((i_sda_oe === 1'b1) | sda_pull);
  // One bus phase
  task automatic ph();
    repeat (dly) @(posedge i_clk);
    #1;
  endtask
  // Release SCL and wait out any stretching
  task automatic scl_up();
    scl_pull = 1'b0;
    while (!o_scl) @(posedge i_clk);
    ph();
  endtask
  // SDA falls while SCL high, then SCL low
  task automatic start_cond();
    sda_pull = 1'b1;
    ph();
    scl_pull = 1'b1;
    ph();
  endtask
  // Data set while SCL low, one SCL pulse
  task automatic send_bit(input logic b);
    sda_pull = ~b;
    ph();
    scl_up();
    scl_pull = 1'b1;
    ph();
  endtask
  // SDA rises while SCL high
  task automatic stop_cond();
    sda_pull = 1'b1;
    ph();
    scl_up();
    sda_pull = 1'b0;
    ph();
  endtask
endmodule // i2cbt_bus_model

//--- tb/test_i2cbt_top.sv
// Self-checking bench of the I2C bit interface
`timescale 1ns/1ps
module test_i2cbt_top;
  import i2cbt_pkg::*;
  localparam int TK = 2; // Shortened timer tick
  logic       i_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       i_scl, i_sda, o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_irq;
  logic [1:0] o_tmr_prio, o_ser_prio;
  logic [7:0] rv, r;
  logic [2:0] pl [4] = '{PRELOAD_0, PRELOAD_1, PRELOAD_2, PRELOAD_3};
  int err_count = 0;
  int tests_run = 0;
  int seed = 58;
  int n;
  `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
  always #2.5 i_clk = ~i_clk;
  i2cbt_top #(.P_TICK_CLKS(TK)) u_i2cbt_top (
    .i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_scl, .o_scl_o,
    .o_scl_oe, .i_sda, .o_sda_o, .o_sda_oe, .o_irq, .o_tmr_prio, .o_ser_prio);
  i2cbt_bus_model u_m (.i_clk, .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe),
    .o_scl(i_scl), .o_sda(i_sda));
  // Register write and read cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // Bounded wait for an enable to reach v, cycles in n
  task automatic wait_oe(input bit sda, input logic v);
    n = 0;
    while ((sda ? o_sda_oe : o_scl_oe) !== v && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(30000);
    err_count++;
    end_of_test();
  end
  initial begin
    cyc(4);
    i_rst_b <= 1'b1;
    cyc(3);
    rd(ADDR_IMASK); `CHK("imask", 8'h1f, rv)
    rd(4'hf); `CHK("unmapped", 8'h00, rv)
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(ADDR_IP1, r);
      wr(ADDR_PRIO_REG_SECOND_HIGH, r ^ 8'h81);
      `CHK("tprio", {~r[7], r[7]}, o_tmr_prio)
      `CHK("sprio", {~r[0], r[0]}, o_ser_prio)
    end
    // Awake slave: start, bits, stretching
    wr(ADDR_CFG, 8'h80);
    u_m.start_cond();
    rd(ADDR_CTRL); `CHK("start", 2'b11, {rv[6], rv[3]})
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      u_m.dly = 3 + r[6:4];
      u_m.send_bit(r[0]);
      wait_oe(0, 1'b1); `CHK("stretch", 1'b1, o_scl_oe)
      rd(ADDR_CTRL); `CHK("data_ready_flag", {r[0], 2'b11}, rv[7:5])
      if (r[1]) wr(ADDR_CTRL, 8'h20);
      else begin
        rd(ADDR_DATA); `CHK("rdat", {r[0], 7'h00}, rv)
      end
      rd(ADDR_CTRL); `CHK("data_ready_flag clr", 1'b0, rv[5])
      wait_oe(0, 1'b0); `CHK("unstretch", 1'b0, o_scl_oe)
    end
    // Interrupt raise, mask, gate, clear
    wr(ADDR_IRQ_ENABLE_REG_FIRST, 8'h80);
    // serial irq only to await stop
    wr(ADDR_IRQ_ENABLE_REG_SECOND, 8'h01);
    rd(ADDR_ISTAT);
    cyc(1); `CHK("irq idle", 1'b0, o_irq)
    u_m.stop_cond();
    cyc(4); `CHK("irq stop", 1'b1, o_irq)
    rd(ADDR_ISTAT); `CHK("istat", 4'b0100, rv[4:1])
    cyc(1); `CHK("irq clr", 1'b0, o_irq)
    wr(ADDR_CTRL, 8'h3c);
    wr(ADDR_IMASK, 8'h00);
    u_m.start_cond();
    cyc(4); `CHK("irq masked", 1'b0, o_irq)
    wr(ADDR_IMASK, 8'h1f);
    cyc(1); `CHK("irq unmask", 1'b1, o_irq)
    wr(ADDR_IRQ_ENABLE_REG_FIRST, 8'h00); `CHK("irq global", 1'b0, o_irq)
    wr(ADDR_IRQ_ENABLE_REG_FIRST, 8'h80);
    rd(ADDR_ISTAT);
    // Hung frame: no timeout without run bit, then timeout
    wr(ADDR_IRQ_ENABLE_REG_SECOND, 8'h80);
    u_m.send_bit(1'b1);
    cyc(1100 * TK); `CHK("no run", 1'b1, o_scl_oe)
    wr(ADDR_CFG, 8'h90);
    cyc(1000 * TK); `CHK("early", 1'b1, o_scl_oe)
    cyc(40 * TK); `CHK("tmo", 1'b0, o_scl_oe)
    `CHK("tmo irq", 1'b1, o_irq)
    rd(ADDR_ISTAT); `CHK("istat tmo", 1'b1, rv[4])
    wr(ADDR_CFG, 8'h00);
    u_m.stop_cond();
    // Master bit at every prescale
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CFG, {6'h10, p[1:0]});
      wait_oe(1, 1'b1);
      wait_oe(0, 1'b1); `CHK("start span", 1'b1, n >= (7 - pl[p]) * TK)
      wr(ADDR_DATA, 8'h80);
      wait_oe(0, 1'b0); `CHK("low span", 1'b1, n + 2 >= (7 - pl[p]) * TK)
      wait_oe(0, 1'b1); `CHK("high span", 1'b1, n >= (7 - pl[p]) * TK)
      cyc(20); `CHK("hold", 1'b1, o_scl_oe)
      rd(ADDR_CTRL); `CHK("master", 3'b111, {rv[7], rv[5], rv[1]})
      wr(ADDR_CTRL, 8'h25);
      wr(ADDR_CFG, 8'h00);
      cyc(80);
      rd(ADDR_CTRL); `CHK("stop", 2'b10, {rv[2], rv[1]})
      `CHK("released", 2'b00, {o_scl_oe, o_sda_oe})
    end
    // Lost arbitration: another master pulls SDA low on a sent one
    wr(ADDR_CFG, 8'h40);
    wait_oe(0, 1'b1);
    wr(ADDR_DATA, 8'h80);
    u_m.sda_pull = 1'b1;
    cyc(60);
    rd(ADDR_CTRL); `CHK("arl", 2'b10, {rv[4], rv[1]})
    `CHK("arl release", 2'b00, {o_scl_oe, o_sda_oe})
    wr(ADDR_CFG, 8'h00);
    u_m.sda_pull = 1'b0;
    cyc(20);
    end_of_test();
  end
endmodule // test_i2cbt_top
